// ### hw/pim_measure.sv
// Purpose: PWM input measurement: counts, cycle time, frequency, duty and level.
// Assumes: pwm_in is asynchronous; software evaluates over AXI4-Lite.
// Notes:   A write to READ_REQ is the host read; it evaluates the latest snapshot.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps

// Notes on behaviour
// - Each host read returns pulses or edges of the chosen kind since the acquisition before the last read.
// - A pulse is counted when its closing edge falls inside the interval.
// - Interval ends are the acquisitions just before each of two host reads.
// - Edge counts use the same acquisition-bounded interval as pulse counts.
// - Count timeout: closing or active edge older than the timeout period.
// - Count timeout in input-dependent mode reports zero.
// - Any timeout in predefined mode reports the configured default value.
// - Cycle time and frequency use the last active edge and its period.
// - Cycle, frequency and duty timeout: last active edge older than period.
// - Input-dependent timeout reports elapsed time, frequency its reciprocal.
// - Duty factor is low over high or high over low.
// - Duty cycle is low or high over low plus high, between 0 and 1.
// - Duty procedure fixes ratio and edge; period chosen as for cycle time.
// - Level reports 1 when active, 0 when inactive, polarity by procedure.
// - Level timeout: last edge of any direction older than the period.
// - Level timeout in input-dependent mode reports the state at acquisition.
// - All evaluation uses the acquisition just before the host read.
// - Edge and acquisition stamps count in 20 ns steps.
// - Inactive means high for low-time and low for high-time measuring.
module pim_measure
  import pim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Measured input pin
  input wire logic pwm_in,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic pin_meta;
    logic pin_s;
    logic pin_d;
    logic [31:0] stamp;
    logic [4:0] res;
    logic [11:0] acq_cnt;
    pim_edges_t live;
    pim_edges_t snap;
    logic [31:0] s_acq;
    logic s_lvl;
    logic [31:0] prev_rc;
    logic [31:0] prev_fc;
    logic [31:0] ctrl;
    logic [31:0] tmo_period;
    logic [31:0] tmo_default;
    pim_state_t state;
    logic [31:0] result;
    logic valid;
    logic tmo_flag;
    logic [47:0] div_num;
    logic [31:0] div_den;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pim_state_all_t;

  pim_state_all_t r;
  pim_state_all_t next_r;

  logic [5:0] res_sum;
  logic rise_e;
  logic fall_e;
  logic acq;
  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic req_take;
  logic [4:0] proc;
  pim_fam_t fam;
  logic falling;
  logic use_rise;
  logic [31:0] p_end;
  logic [31:0] p_start;
  logic [31:0] p_mid;
  logic [31:0] last_any;
  logic [31:0] ref_edge;
  logic [31:0] elapsed;
  logic [31:0] el_any;
  logic tmo;
  logic predef;
  logic [31:0] hi;
  logic [31:0] lo;
  logic [32:0] sum;
  logic [31:0] sum_sat;
  logic [31:0] cyc;
  logic [31:0] cnt_val;
  logic [31:0] val;
  logic need_div;
  logic [47:0] num;
  logic [31:0] den;
  logic div_done;
  logic [31:0] div_q;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] o;
    o = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return o;
  endfunction : apply_strb

  // Evaluation of the latest snapshot
  always_comb begin
    proc = r.ctrl[4:0];
    fam = pim_family(proc);
    predef = r.ctrl[CTRL_PREDEF_BIT];
    falling = proc[0];
    use_rise = (proc == P_LOW_PULSES) || (proc == P_RISE_EDGES);
    p_end = falling ? r.snap.f : r.snap.r;
    p_start = falling ? r.snap.pf : r.snap.pr;
    p_mid = falling ? (r.snap.rise ? r.snap.pr : r.snap.r) : (r.snap.rise ? r.snap.f : r.snap.pf);
    last_any = r.snap.rise ? r.snap.r : r.snap.f;
    el_any = r.s_acq - last_any;
    case (fam)
      FAM_CNT: ref_edge = use_rise ? r.snap.r : r.snap.f;
      FAM_LVL: ref_edge = last_any;
      default: ref_edge = p_end;
    endcase
    elapsed = r.s_acq - ref_edge;
    tmo = r.ctrl[CTRL_TMO_EN_BIT] && (elapsed > r.tmo_period);
    hi = falling ? (p_end - p_mid) : (p_mid - p_start);
    lo = falling ? (p_mid - p_start) : (p_end - p_mid);
    if (tmo) begin
      // Phase of the present level runs up to the acquisition
      hi = r.snap.rise ? el_any : (r.snap.f - r.snap.r);
      lo = r.snap.rise ? (r.snap.r - r.snap.f) : el_any;
    end
    sum = {1'b0, lo} + {1'b0, hi};
    sum_sat = sum[32] ? 32'hffff_ffff : sum[31:0];
    cyc = tmo ? elapsed : (p_end - p_start);
    cnt_val = use_rise ? (r.snap.rc - r.prev_rc) : (r.snap.fc - r.prev_fc);
    val = 32'h0;
    need_div = 1'b0;
    num = TS_PER_SEC;
    den = cyc;
    case (fam)
      FAM_CNT: val = tmo ? 32'h0 : cnt_val;
      FAM_CYC: val = cyc;
      FAM_FREQ: need_div = 1'b1;
      FAM_DF: begin
        need_div = 1'b1;
        num = {proc[1] ? hi : lo, 16'h0};
        den = proc[1] ? lo : hi;
      end
      FAM_DC: begin
        need_div = 1'b1;
        num = {proc[1] ? hi : lo, 16'h0};
        den = sum_sat;
      end
      default: val = {31'h0, (proc == P_LVL_L) ? ~r.s_lvl : r.s_lvl};
    endcase
    if (tmo && predef) begin
      val = r.tmo_default;
      need_div = 1'b0;
    end
  end

  always_comb begin
    next_r = r;
    next_r.pin_meta = pwm_in;
    next_r.pin_s = r.pin_meta;
    next_r.pin_d = r.pin_s;
    // Time stamp advances 25 ns per clock in 20 ns steps
    res_sum = 6'(r.res) + 6'(CLK_PERIOD_NS);
    next_r.stamp = r.stamp + 32'(res_sum / 6'(TS_RES_NS));
    next_r.res = 5'(res_sum % 6'(TS_RES_NS));
    rise_e = r.pin_s & ~r.pin_d;
    fall_e = ~r.pin_s & r.pin_d;
    if (rise_e) begin
      next_r.live.pr = r.live.r;
      next_r.live.r = r.stamp;
      next_r.live.rise = 1'b1;
      next_r.live.rc = r.live.rc + 32'h1;
    end
    if (fall_e) begin
      next_r.live.pf = r.live.f;
      next_r.live.f = r.stamp;
      next_r.live.rise = 1'b0;
      next_r.live.fc = r.live.fc + 32'h1;
    end
    acq = (r.acq_cnt == 12'h0);
    next_r.acq_cnt = acq ? ACQ_RELOAD : (r.acq_cnt - 12'h1);
    if (acq) begin
      next_r.snap = r.live;
      next_r.s_acq = r.stamp;
      next_r.s_lvl = r.pin_s;
    end
    // Write channel: address and data taken in either order
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    if (aw_hs) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    wa = r.aw_got ? r.awaddr : s_axi_awaddr;
    wd = r.w_got ? r.wdata : s_axi_wdata;
    ws = r.w_got ? r.wstrb : s_axi_wstrb;
    wr_go = (r.aw_got || aw_hs) && (r.w_got || w_hs);
    req_take = 1'b0;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (wa)
        OFS_CTRL: next_r.ctrl = apply_strb(r.ctrl, wd, ws) & CTRL_MASK;
        OFS_TMO_PERIOD: next_r.tmo_period = apply_strb(r.tmo_period, wd, ws);
        OFS_TMO_DEFAULT: next_r.tmo_default = apply_strb(r.tmo_default, wd, ws);
        OFS_READ_REQ: req_take = (r.state == S_IDLE);
        OFS_STATUS, OFS_RESULT, OFS_ACQ_STAMP: next_r.bresp = RESP_OKAY;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    // Read channel
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0;
      case (s_axi_araddr)
        OFS_CTRL: next_r.rdata = r.ctrl;
        OFS_TMO_PERIOD: next_r.rdata = r.tmo_period;
        OFS_TMO_DEFAULT: next_r.rdata = r.tmo_default;
        OFS_READ_REQ: next_r.rdata = 32'h0;
        OFS_STATUS: begin
          next_r.rdata[STAT_BUSY_BIT] = (r.state != S_IDLE);
          next_r.rdata[STAT_VALID_BIT] = r.valid;
          next_r.rdata[STAT_TMO_BIT] = r.tmo_flag;
          next_r.rdata[STAT_LEVEL_BIT] = r.s_lvl;
        end
        OFS_RESULT: next_r.rdata = r.result;
        OFS_ACQ_STAMP: next_r.rdata = r.s_acq;
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
    // Evaluation sequence
    case (r.state)
      S_IDLE: begin
        if (req_take) begin
          next_r.prev_rc = r.snap.rc;
          next_r.prev_fc = r.snap.fc;
          next_r.tmo_flag = tmo;
          next_r.result = val;
          next_r.valid = !need_div;
          next_r.div_num = num;
          next_r.div_den = den;
          next_r.state = need_div ? S_CALC : S_IDLE;
        end
      end
      S_CALC: next_r.state = S_DIV;
      S_DIV: begin
        if (div_done) begin
          next_r.result = div_q;
          next_r.valid = 1'b1;
          next_r.state = S_IDLE;
        end
      end
      default: next_r.state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.tmo_period <= TMO_PERIOD_RST;
      r.tmo_default <= TMO_DEFAULT_RST;
      r.state <= S_IDLE;
    end else begin
      r <= next_r;
    end
  end

  pim_divider u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(r.state == S_CALC),
    .dividend(r.div_num),
    .divisor(r.div_den),
    .done(div_done),
    .quotient(div_q)
  );

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence seq_div_req;
    req_take && need_div;
  endsequence

  sequence seq_div_answer;
    ##[50:52] $rose(r.valid);
  endsequence

  chk_div_latency: assert property (
    seq_div_req |-> ##1 !r.valid ##0 seq_div_answer)
    else $error("divided result not ready in time");
  chk_count_timeout: assert property (
    req_take && fam == FAM_CNT && tmo && !predef |=> r.result == 32'h0 && r.tmo_flag)
    else $error("count timeout did not report zero");
  chk_predef_value: assert property (
    req_take && tmo && predef |=> r.valid && r.result == $past(r.tmo_default))
    else $error("predefined timeout value not reported");
  chk_interval_edge: assert property (
    req_take |=> r.prev_rc == $past(r.snap.rc) && r.prev_fc == $past(r.snap.fc))
    else $error("count interval not moved to latest acquisition");
  chk_level_value: assert property (
    req_take && proc == P_LVL_L && !(tmo && predef) |=> r.result == {31'h0, ~$past(r.s_lvl)})
    else $error("active low level misreported");
  chk_stamp_step: assert property (
    $past(rstn) |-> (r.stamp - $past(r.stamp)) == 32'h1 || (r.stamp - $past(r.stamp)) == 32'h2)
    else $error("time stamp step outside 20 ns grid");
  chk_edge_record: assert property (
    rise_e |=> r.live.r == $past(r.stamp) && r.live.rise)
    else $error("rising edge not recorded");
  chk_acq_snapshot: assert property (
    acq |=> r.s_acq == $past(r.stamp) && r.snap.rc == $past(r.live.rc))
    else $error("snapshot not taken at acquisition");
  chk_write_resp: assert property (
    wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");

endmodule : pim_measure

// ### hw/pim_pkg.sv
// Purpose: Constants, register map and types of the PWM input measurement block.
// Assumes: 40 MHz reference clock, time stamps counted in 20 ns steps.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package pim_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TS_RES_NS = 20;
  localparam logic [47:0] TS_PER_SEC = 48'(1000000000 / TS_RES_NS);
  localparam int FRAC_BITS = 16;

  // Data acquisition period of the measurement snapshot
  localparam int ACQ_PERIOD_NS = 10000;
  localparam int ACQ_CYCLES = ACQ_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] ACQ_RELOAD = 12'(ACQ_CYCLES - 1);

  // Divider
  localparam logic [5:0] DIV_STEPS = 6'h30;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TMO_PERIOD = 8'h04;
  localparam logic [7:0] OFS_TMO_DEFAULT = 8'h08;
  localparam logic [7:0] OFS_READ_REQ = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_ACQ_STAMP = 8'h18;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TMO_PERIOD_RST = 32'h0001_86a0;
  localparam logic [31:0] TMO_DEFAULT_RST = 32'h0000_0000;

  // Field positions
  localparam logic [31:0] CTRL_MASK = 32'h0000_031f;
  localparam int CTRL_TMO_EN_BIT = 8;
  localparam int CTRL_PREDEF_BIT = 9;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam int STAT_LEVEL_BIT = 3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    P_LOW_PULSES = 5'h00, P_HIGH_PULSES = 5'h01, P_RISE_EDGES = 5'h02, P_FALL_EDGES = 5'h03,
    P_CYC_R = 5'h04, P_CYC_F = 5'h05, P_FREQ_R = 5'h06, P_FREQ_F = 5'h07,
    P_DF_LH_R = 5'h08, P_DF_LH_F = 5'h09, P_DF_HL_R = 5'h0a, P_DF_HL_F = 5'h0b,
    P_DC_L_R = 5'h0c, P_DC_L_F = 5'h0d, P_DC_H_R = 5'h0e, P_DC_H_F = 5'h0f,
    P_LVL_H = 5'h10, P_LVL_L = 5'h11
  } pim_proc_t;

  typedef enum logic [2:0] {
    FAM_CNT = 3'h0, FAM_CYC = 3'h1, FAM_FREQ = 3'h2, FAM_DF = 3'h3, FAM_DC = 3'h4, FAM_LVL = 3'h5
  } pim_fam_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CALC = 3'b010,
    S_DIV = 3'b100
  } pim_state_t;

  // Last two edges of each direction and the edge totals
  typedef struct packed {
    logic [31:0] r;
    logic [31:0] pr;
    logic [31:0] f;
    logic [31:0] pf;
    logic rise;
    logic [31:0] rc;
    logic [31:0] fc;
  } pim_edges_t;

  function automatic pim_fam_t pim_family(input logic [4:0] p);
    pim_fam_t fam;
    if (p < 5'h04) begin
      fam = FAM_CNT;
    end else if (p < 5'h06) begin
      fam = FAM_CYC;
    end else if (p < 5'h08) begin
      fam = FAM_FREQ;
    end else if (p < 5'h0c) begin
      fam = FAM_DF;
    end else if (p < 5'h10) begin
      fam = FAM_DC;
    end else begin
      fam = FAM_LVL;
    end
    return fam;
  endfunction : pim_family

endpackage : pim_pkg

// ### hw/pim_divider.sv
// Purpose: Serial restoring divider, 48-bit dividend by 32-bit divisor.
// Assumes: Divisor and dividend stay stable from start until done.
// Notes:   Quotient saturates to all ones; division by zero gives all ones.
`timescale 1ns/100ps
module pim_divider
  import pim_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire logic [47:0] dividend,
  input wire logic [31:0] divisor,
  // Answer
  output logic done,
  output logic [31:0] quotient
);

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [47:0] quo;
    logic done;
    logic [31:0] q;
  } pim_div_state_t;

  pim_div_state_t r;
  pim_div_state_t next_r;
  logic [32:0] rem_sh;
  logic [47:0] next_quo;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    rem_sh = {r.rem[31:0], r.quo[47]};
    next_quo = {r.quo[46:0], 1'b0};
    if (start) begin
      next_r.busy = 1'b1;
      next_r.cnt = DIV_STEPS;
      next_r.rem = 33'h0;
      next_r.quo = dividend;
    end else if (r.busy) begin
      if (rem_sh >= {1'b0, divisor}) begin
        next_r.rem = rem_sh - {1'b0, divisor};
        next_quo = {r.quo[46:0], 1'b1};
      end else begin
        next_r.rem = rem_sh;
      end
      next_r.quo = next_quo;
      next_r.cnt = r.cnt - 6'h01;
      if (r.cnt == 6'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
        next_r.q = (next_quo[47:32] != 16'h0) ? 32'hffff_ffff : next_quo[31:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;
  assign quotient = r.q;

endmodule : pim_divider

// ### tb/pim_host_model.sv
// Purpose: Host driver model, an AXI4-Lite master that reads the measurement data.
// Assumes: One write and one read at most under way; the bench calls the tasks.
// Notes:   Waits are bounded; ok stays low when the slave never answers.
`timescale 1ns/100ps
module pim_host_model
  import pim_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Write channels
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Released payload is inverted so a late sample shows up as wrong data
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    ok = 1'b0;
    r = 2'h3;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        ok = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit ok);
    int n;
    ok = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        ok = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : rd
endmodule : pim_host_model

// ### tb/tb_pim_measure.sv
// Purpose: Self-checking bench of the PWM input measurement block.
// Assumes: Host model drives the bus; bench drives the pin in whole clocks.
// Notes:   12 clocks high, 28 low give 15, 35 and 50 stamp ticks exactly.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_pim_measure
  import pim_pkg::*;
;
  localparam int TH = 12;
  localparam int TP = 40;
  localparam logic [31:0] HT = 32'd15;
  localparam logic [31:0] LT = 32'd35;
  localparam logic [31:0] PT = 32'd50;
  localparam logic [31:0] FQ = 32'(TS_PER_SEC / {16'h0, PT});
  typedef struct {logic [4:0] proc; int burst; logic [31:0] exp;} pim_row_t;
  pim_row_t rows[16] = '{
    '{5'h04, 0, PT}, '{5'h05, 0, PT}, '{5'h06, 0, FQ}, '{5'h07, 0, FQ},
    '{5'h08, 0, (LT << 16) / HT}, '{5'h09, 0, (LT << 16) / HT},
    '{5'h0a, 0, (HT << 16) / LT}, '{5'h0b, 0, (HT << 16) / LT},
    '{5'h0c, 0, (LT << 16) / PT}, '{5'h0d, 0, (LT << 16) / PT},
    '{5'h0e, 0, (HT << 16) / PT}, '{5'h0f, 0, (HT << 16) / PT},
    '{5'h00, 3, 32'd3}, '{5'h01, 5, 32'd5}, '{5'h02, 2, 32'd2}, '{5'h03, 4, 32'd4}};
  logic ref_clk, rstn, pwm_in, pwm_man, run;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, st, s0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, ctl_hi;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int tests_run, fail_count, ph, k;

  pim_measure i_pim_measure (.ref_clk, .rstn, .pwm_in, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pim_host_model i_pim_host_model (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Free-running PWM source while run is high, else the hand-driven level
  always @(posedge ref_clk) begin
    if (run) begin
      ph <= (ph == TP - 1) ? 0 : ph + 1;
    end
    pwm_in <= run ? (ph < TH) : pwm_man;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ok;
    i_pim_host_model.wr(a, v, rs, ok);
    if (!ok) begin
      fail_count++;
      final_report();
    end
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit ok;
    i_pim_host_model.rd(a, v, rs, ok);
    if (!ok) begin
      fail_count++;
      final_report();
    end
  endtask : bus_rd

  // One host read: select procedure, trigger, poll until the result stands
  task automatic meas(input logic [4:0] p, output logic [31:0] res, output logic [31:0] s);
    int n;
    logic [1:0] rs;
    bus_wr(OFS_CTRL, {22'h0, ctl_hi, 3'h0, p}, rs);
    bus_wr(OFS_READ_REQ, 32'h0, rs);
    s = 32'h0;
    for (n = 0; n < 40 && !(s[STAT_VALID_BIT] === 1'b1 && s[STAT_BUSY_BIT] === 1'b0); n++) begin
      bus_rd(OFS_STATUS, s, rs);
    end
    if (s[STAT_VALID_BIT] !== 1'b1 || s[STAT_BUSY_BIT] !== 1'b0) begin
      fail_count++;
      final_report();
    end
    bus_rd(OFS_RESULT, res, rs);
  endtask : meas

  task automatic pulses(input int n);
    repeat (n) begin
      pwm_man <= 1'b1;
      idle(4);
      pwm_man <= 1'b0;
      idle(4);
    end
  endtask : pulses

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial begin
    {rstn, pwm_man, run, ctl_hi, tests_run, fail_count} = '0;
    idle(12);
    rstn <= 1'b1;
    bus_rd(OFS_CTRL, d, r);
    `CHK("ctrl reset", CTRL_RST, d)
    `CHK("read resp", RESP_OKAY, r)
    bus_rd(OFS_TMO_PERIOD, d, r);
    `CHK("period reset", TMO_PERIOD_RST, d)
    bus_rd(OFS_TMO_DEFAULT, d, r);
    `CHK("default reset", TMO_DEFAULT_RST, d)
    bus_rd(8'h1c, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    bus_wr(8'h1c, 32'h0, r);
    `CHK("unmapped wr resp", RESP_SLVERR, r)
    bus_wr(OFS_CTRL, 32'hffff_ffff, r);
    `CHK("write resp", RESP_OKAY, r)
    bus_rd(OFS_CTRL, d, r);
    `CHK("ctrl mask", CTRL_MASK, d)
    run <= 1'b1;
    idle(500);
    foreach (rows[i]) begin
      if (rows[i].burst > 0) begin
        if (run) begin
          run <= 1'b0;
          idle(450);
        end
        meas(rows[i].proc, d, st);
        pulses(rows[i].burst);
        idle(450);
      end
      meas(rows[i].proc, d, st);
      `CHK("row result", rows[i].exp, d)
      `CHK("row timeout", 1'b0, st[STAT_TMO_BIT])
    end
    // Pulse just after an acquisition belongs to the next interval
    meas(5'h02, d, st);
    bus_rd(OFS_ACQ_STAMP, s0, r);
    d = s0;
    for (k = 0; k < 200 && d === s0; k++) begin
      bus_rd(OFS_ACQ_STAMP, d, r);
    end
    `CHK("acq advanced", 1'b1, d !== s0)
    pulses(1);
    meas(5'h02, d, st);
    `CHK("edge after acq", 32'd0, d)
    idle(450);
    meas(5'h02, d, st);
    `CHK("edge next read", 32'd1, d)
    // Input-dependent timeouts on a quiet pin
    bus_wr(OFS_TMO_PERIOD, 32'd100, r);
    ctl_hi = 2'h1;
    meas(5'h02, d, st);
    `CHK("count timeout", 32'd0, d)
    `CHK("count tmo flag", 1'b1, st[STAT_TMO_BIT])
    meas(5'h04, d, st);
    `CHK("cycle elapsed", 1'b1, d > 32'd100)
    `CHK("cycle tmo flag", 1'b1, st[STAT_TMO_BIT])
    meas(5'h06, d, st);
    `CHK("freq reciprocal", 1'b1, d < FQ / 2)
    // Level with the pin held high, long enough that every acquisition phase times out
    pwm_man <= 1'b1;
    idle(900);
    meas(5'h10, d, st);
    `CHK("level high", 32'd1, d)
    `CHK("level tmo flag", 1'b1, st[STAT_TMO_BIT])
    `CHK("level status", 1'b1, st[STAT_LEVEL_BIT])
    meas(5'h11, d, st);
    `CHK("level low act", 32'd0, d)
    // Predefined mode returns the default for the count, duty factor and level families
    bus_wr(OFS_TMO_DEFAULT, 32'h5a5a_0123, r);
    ctl_hi = 2'h3;
    for (k = 0; k < 3; k++) begin
      meas(5'(k * 8), d, st);
      `CHK("predefined", 32'h5a5a_0123, d)
    end
    // New edges clear the timeout
    ctl_hi = 2'h1;
    run <= 1'b1;
    idle(900);
    meas(5'h04, d, st);
    `CHK("cleared value", PT, d)
    `CHK("cleared flag", 1'b0, st[STAT_TMO_BIT])
    // Reset in mid-run restores the registers
    rstn <= 1'b0;
    idle(3);
    rstn <= 1'b1;
    bus_rd(OFS_TMO_PERIOD, d, r);
    `CHK("period rereset", TMO_PERIOD_RST, d)
    final_report();
  end
endmodule : tb_pim_measure
